// File: wlucl_pkg.sv
// Shared constants, types and field layouts of the configuration loader
package wlucl_pkg;

	// ------------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------------
	localparam int APB_AW  = 8;
	localparam int MEM_AW  = 9;
	localparam int IDX_W   = 5;
	localparam int NBYTES  = 32;

	// ------------------------------------------------------------------
	// Register byte offsets on APB
	// ------------------------------------------------------------------
	localparam logic [APB_AW-1:0] OFS_LOADER    = 8'h00;
	localparam logic [APB_AW-1:0] OFS_ATTR      = 8'h04;
	localparam logic [APB_AW-1:0] OFS_HWCFG     = 8'h08;
	localparam logic [APB_AW-1:0] OFS_IND_MODE  = 8'h0C;
	localparam logic [APB_AW-1:0] OFS_IND_BEHAV = 8'h10;
	localparam logic [APB_AW-1:0] OFS_AFE       = 8'h14;
	localparam logic [APB_AW-1:0] OFS_USB_A     = 8'h18;
	localparam logic [APB_AW-1:0] OFS_USB_B     = 8'h1C;
	localparam logic [APB_AW-1:0] OFS_WAKE_STAT = 8'h20;
	localparam logic [APB_AW-1:0] OFS_FILT_CFG  = 8'h24;
	localparam logic [APB_AW-1:0] OFS_FILT_MASK = 8'h28;
	localparam logic [APB_AW-1:0] OFS_FILT_LAST = 8'h34;

	// ------------------------------------------------------------------
	// Configuration memory map and signature (signature value arbitrary)
	// ------------------------------------------------------------------
	localparam logic [MEM_AW-1:0] MEM_SIG_ADDR   = 9'h000;
	localparam logic [MEM_AW-1:0] MEM_WAKE0_ADDR = 9'h062;
	localparam logic [MEM_AW-1:0] MEM_WAKE1_ADDR = 9'h063;
	localparam logic [MEM_AW-1:0] MEM_IND0_ADDR  = 9'h064;
	localparam logic [MEM_AW-1:0] MEM_IND1_ADDR  = 9'h065;
	localparam logic [MEM_AW-1:0] MEM_IND2_ADDR  = 9'h066;
	localparam logic [MEM_AW-1:0] MEM_IND3_ADDR  = 9'h058;
	localparam logic [MEM_AW-1:0] MEM_IND4_ADDR  = 9'h059;
	localparam logic [MEM_AW-1:0] MEM_CFG0_ADDR  = 9'h068;
	localparam logic [MEM_AW-1:0] MEM_FILT_ADDR  = 9'h070;
	localparam logic [7:0]        SIG_VALUE      = 8'hA5;

	// ------------------------------------------------------------------
	// Fetch step indices into the shadow byte array
	// ------------------------------------------------------------------
	localparam logic [IDX_W-1:0] IDX_SIG       = 5'h00;
	localparam logic [IDX_W-1:0] IDX_WAKE0     = 5'h01;
	localparam logic [IDX_W-1:0] IDX_WAKE1     = 5'h02;
	localparam logic [IDX_W-1:0] IDX_IND0      = 5'h03;
	localparam logic [IDX_W-1:0] IDX_IND1      = 5'h04;
	localparam logic [IDX_W-1:0] IDX_IND2      = 5'h05;
	localparam logic [IDX_W-1:0] IDX_IND3      = 5'h06;
	localparam logic [IDX_W-1:0] IDX_IND4      = 5'h07;
	localparam logic [IDX_W-1:0] IDX_CFG0      = 5'h08;
	localparam logic [IDX_W-1:0] IDX_HDR_LAST  = 5'h0B;
	localparam logic [IDX_W-1:0] IDX_FILT      = 5'h0C;
	localparam logic [IDX_W-1:0] IDX_FILT_MASK = 5'h10;
	localparam logic [IDX_W-1:0] IDX_FILT_LAST = 5'h1F;

	// ------------------------------------------------------------------
	// Source byte fields
	// ------------------------------------------------------------------
	localparam int WK0_EXACT  = 0;
	localparam int WK0_PACKET = 1;
	localparam int WK0_LINK   = 2;
	localparam int WK0_MASTER = 7;
	localparam int WK1_WUF    = 0;
	localparam int WK1_BCAST  = 1;
	localparam logic [7:0] WK0_MASK  = 8'h87;
	localparam logic [7:0] WK1_MASK  = 8'h03;
	localparam logic [7:0] IND0_MASK = 8'h0F;
	localparam int CF_SQU_HI     = 29;
	localparam int CF_SQU_LO     = 27;
	localparam int CF_DEEP_INIT  = 26;
	localparam int CF_DEEP_EN    = 25;
	localparam int CF_LIGHT_INIT = 24;
	localparam int CF_LIGHT_EN   = 23;
	localparam int CF_LTM        = 22;
	localparam int CF_SUSP       = 20;

	// ------------------------------------------------------------------
	// Target register fields, write masks and reset values
	// ------------------------------------------------------------------
	localparam int ATTR_EXACT  = 0;
	localparam int ATTR_PACKET = 1;
	localparam int ATTR_LINK   = 2;
	localparam int ATTR_MASTER = 7;
	localparam int ATTR_WUF    = 8;
	localparam int ATTR_BCAST  = 9;
	localparam int HWC_PROTECT = 4;
	localparam int USBB_LIGHT_EN   = 0;
	localparam int USBB_LIGHT_INIT = 1;
	localparam int USBB_DEEP_EN    = 2;
	localparam int USBB_DEEP_INIT  = 3;
	localparam int USBB_LTM        = 4;
	localparam int USBA_SUSP       = 0;
	localparam int LDS_DONE  = 0;
	localparam int LDS_VALID = 1;
	localparam int LDS_BUSY  = 2;
	localparam logic [31:0] ATTR_WMASK  = 32'h0000_0387;
	localparam logic [31:0] HWC_WMASK   = 32'h0000_001F;
	localparam logic [31:0] MODE_WMASK  = 32'h0000_FFFF;
	localparam logic [31:0] AFE_WMASK   = 32'h0000_0007;
	localparam logic [31:0] USBA_WMASK  = 32'h0000_0001;
	localparam logic [31:0] USBB_WMASK  = 32'h0000_001F;
	localparam logic [31:0] RST_ATTR    = 32'h0000_0000;
	localparam logic [31:0] RST_HWC     = 32'h0000_0000;
	localparam logic [31:0] RST_MODE    = 32'h0000_0000;
	localparam logic [31:0] RST_BEHAV   = 32'h0000_0000;
	localparam logic [31:0] RST_AFE     = 32'h0000_0000;
	localparam logic [31:0] RST_USBA    = 32'h0000_0000;
	localparam logic [31:0] RST_USBB    = 32'h0000_0000;
	localparam logic [31:0] ZERO32      = 32'h0000_0000;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		LD_START,
		LD_FETCH,
		LD_WAIT,
		LD_APPLY,
		LD_DONE
	} wlucl_ld_e;

	typedef struct packed {
		logic wake_frame;
		logic broadcast;
		logic link_change;
		logic packet;
		logic exact_dest;
	} wlucl_wake_ev_s;

	typedef struct packed {
		logic              req;
		logic [MEM_AW-1:0] addr;
	} wlucl_mem_req_s;

	typedef struct packed {
		logic [31:0]  wake_attr;
		logic [31:0]  hardware_configuration_reg;
		logic [31:0]  ind_mode;
		logic [31:0]  ind_behav;
		logic [31:0]  afe_ctrl;
		logic [31:0]  usb_cfg_a;
		logic [31:0]  usb_cfg_b;
		logic [31:0]  filt_cfg;
		logic [127:0] filt_mask;
	} wlucl_cfg_s;

	// Memory address of one fetch step
	function automatic logic [MEM_AW-1:0] step_addr(
		input logic [IDX_W-1:0] idx
	);
		logic [MEM_AW-1:0] a;
		a = MEM_SIG_ADDR;
		if (idx == IDX_WAKE0) a = MEM_WAKE0_ADDR;
		else if (idx == IDX_WAKE1) a = MEM_WAKE1_ADDR;
		else if (idx == IDX_IND0) a = MEM_IND0_ADDR;
		else if (idx == IDX_IND1) a = MEM_IND1_ADDR;
		else if (idx == IDX_IND2) a = MEM_IND2_ADDR;
		else if (idx == IDX_IND3) a = MEM_IND3_ADDR;
		else if (idx == IDX_IND4) a = MEM_IND4_ADDR;
		else if (idx >= IDX_FILT)
			a = MEM_FILT_ADDR + MEM_AW'(idx - IDX_FILT);
		else if (idx >= IDX_CFG0)
			a = MEM_CFG0_ADDR + MEM_AW'(idx - IDX_CFG0);
		return a;
	endfunction : step_addr

endpackage : wlucl_pkg

// File: wlucl_byte_fetch.sv
// Single-byte read engine toward the configuration memory
`timescale 1ns/1ps
module wlucl_byte_fetch
	import wlucl_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              start,
	input  wire logic [MEM_AW-1:0] addr,
	output wlucl_mem_req_s         mem_out,
	input  wire logic              mem_ack,
	input  wire logic [7:0]        mem_rdata,
	output logic                   done,
	output logic [7:0]             data
);
	logic              req_r;
	logic [MEM_AW-1:0] addr_r;
	logic              done_r;
	logic [7:0]        data_r;

	// ------------------------------------------------------------------
	// Request held until the memory acknowledges
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			req_r  <= 1'b0;
			addr_r <= MEM_SIG_ADDR;
		end
		else if (start)
		begin
			req_r  <= 1'b1;
			addr_r <= addr;
		end
		else if (mem_ack)
			req_r <= 1'b0;
	end

	// Byte capture and one-cycle completion pulse
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			done_r <= 1'b0;
			data_r <= 8'h00;
		end
		else
		begin
			done_r <= req_r && mem_ack;
			if (req_r && mem_ack)
				data_r <= mem_rdata;
		end
	end

	assign mem_out.req  = req_r;
	assign mem_out.addr = addr_r;
	assign done         = done_r;
	assign data         = data_r;

endmodule : wlucl_byte_fetch

// File: wlucl_loader.sv
// Configuration loader with APB register file and wake pin gating
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
module wlucl_loader
	import wlucl_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [APB_AW-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              lite_reset,
	output wlucl_mem_req_s         cfg_mem_out,
	input  wire logic              cfg_mem_ack,
	input  wire logic [7:0]        cfg_mem_rdata,
	input  wlucl_wake_ev_s         wake_ev,
	output logic                   power_event_pin_n,
	output wlucl_cfg_s             cfg_out
);
	wlucl_ld_e        state_r;
	logic [IDX_W-1:0] idx_r;
	logic             valid_r;
	logic [7:0]       shadow_r [0:NBYTES-1];
	logic             fetch_done;
	logic [7:0]       fetch_data;
	logic             apply;
	logic             wuf_want;
	logic             protect;
	logic [31:0]      attr_r;
	logic [31:0]      hwc_r;
	logic [31:0]      mode_r;
	logic [31:0]      behav_r;
	logic [31:0]      afe_r;
	logic [31:0]      usba_r;
	logic [31:0]      usbb_r;
	logic [31:0]      fcfg_r;
	logic [31:0]      fmask_r [0:3];
	logic [4:0]       pend_r;
	logic [31:0]      prdata_r;
	logic [31:0]      rd_nxt;
	logic             rd_hit;
	logic             acc;
	logic [4:0]       wake_en;
	logic [31:0]      cfg0;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Write strobe for one register, taken in the access phase
	function automatic logic wr_hit(input logic [APB_AW-1:0] ofs);
		return psel && penable && pwrite && (paddr == ofs);
	endfunction : wr_hit

	// Little-endian word from four shadow bytes
	function automatic logic [31:0] word_at(input logic [IDX_W-1:0] b);
		return {shadow_r[b + 5'h03], shadow_r[b + 5'h02],
			shadow_r[b + 5'h01], shadow_r[b]};
	endfunction : word_at

	assign apply    = (state_r == LD_APPLY);
	assign protect  = hwc_r[HWC_PROTECT];
	assign cfg0     = word_at(IDX_CFG0);
	assign wuf_want = shadow_r[IDX_WAKE1][WK1_WUF];
	assign acc      = psel && penable;

	// ------------------------------------------------------------------
	// Loader sequencer
	// ------------------------------------------------------------------
	// Walks the step table once; a bad signature ends it with no load
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= LD_START;
			idx_r   <= IDX_SIG;
			valid_r <= 1'b0;
		end
		else if (lite_reset)
		begin
			state_r <= LD_START;
			idx_r   <= IDX_SIG;
			valid_r <= 1'b0;
		end
		else
		begin
			case (state_r)
			LD_START:
			begin
				idx_r   <= IDX_SIG;
				state_r <= LD_FETCH;
			end
			LD_FETCH:
				state_r <= LD_WAIT;
			LD_WAIT:
				if (fetch_done)
				begin
					if (idx_r == IDX_SIG && fetch_data != SIG_VALUE)
						state_r <= LD_DONE;
					else if (idx_r == IDX_HDR_LAST && !wuf_want)
						state_r <= LD_APPLY;
					else if (idx_r == IDX_FILT_LAST)
						state_r <= LD_APPLY;
					else
					begin
						idx_r   <= idx_r + 5'h01;
						state_r <= LD_FETCH;
					end
				end
			LD_APPLY:
			begin
				valid_r <= 1'b1;
				state_r <= LD_DONE;
			end
			default:
				state_r <= LD_DONE;
			endcase
		end
	end

	// Shadow copy of every fetched byte
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < NBYTES; i++)
				shadow_r[i] <= 8'h00;
		end
		else if (fetch_done)
			shadow_r[idx_r] <= fetch_data;
	end

	wlucl_byte_fetch u_fetch (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (state_r == LD_FETCH),
		.addr      (step_addr(idx_r)),
		.mem_out   (cfg_mem_out),
		.mem_ack   (cfg_mem_ack),
		.mem_rdata (cfg_mem_rdata),
		.done      (fetch_done),
		.data      (fetch_data)
	);

	// ------------------------------------------------------------------
	// Target registers
	// ------------------------------------------------------------------
	// Wake attributes: seeded from both wake bytes, then software-owned
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			attr_r <= RST_ATTR;
		else if (lite_reset)
			attr_r <= RST_ATTR;
		else if (apply)
			attr_r <= {16'h0000, shadow_r[IDX_WAKE1] & WK1_MASK,
				shadow_r[IDX_WAKE0] & WK0_MASK};
		else if (wr_hit(OFS_ATTR))
			attr_r <= pwdata & ATTR_WMASK;
	end

	// Hardware config; protect bit survives the lite reset on purpose
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			hwc_r <= RST_HWC;
		else if (lite_reset)
			hwc_r <= (RST_HWC & ~HWC_WMASK) | (hwc_r & (32'h1 << HWC_PROTECT));
		else if (apply)
			hwc_r <= {hwc_r[31:8],
				shadow_r[IDX_IND0] & IND0_MASK | hwc_r[7:0] & ~IND0_MASK};
		else if (wr_hit(OFS_HWCFG))
			hwc_r <= pwdata & HWC_WMASK;
	end

	// Indicator function select, shielded while protect is set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_r <= RST_MODE;
		else if (lite_reset && !protect)
			mode_r <= RST_MODE;
		else if (apply && !protect)
			mode_r <= {16'h0000, shadow_r[IDX_IND2],
				shadow_r[IDX_IND1]};
		else if (wr_hit(OFS_IND_MODE))
			mode_r <= pwdata & MODE_WMASK;
	end

	// Indicator behaviour word, shielded the same way
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			behav_r <= RST_BEHAV;
		else if (lite_reset && !protect)
			behav_r <= RST_BEHAV;
		else if (apply && !protect)
			behav_r <= {16'h0000, shadow_r[IDX_IND4],
				shadow_r[IDX_IND3]};
		else if (wr_hit(OFS_IND_BEHAV))
			behav_r <= pwdata & MODE_WMASK;
	end

	// Analogue front end: squelch tuning default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			afe_r <= RST_AFE;
		else if (lite_reset)
			afe_r <= RST_AFE;
		else if (apply)
			afe_r <= {29'h0, cfg0[CF_SQU_HI:CF_SQU_LO]};
		else if (wr_hit(OFS_AFE))
			afe_r <= pwdata & AFE_WMASK;
	end

	// USB configuration A: suspend allow default
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			usba_r <= RST_USBA;
		else if (lite_reset)
			usba_r <= RST_USBA;
		else if (apply)
			usba_r <= {31'h0, cfg0[CF_SUSP]};
		else if (wr_hit(OFS_USB_A))
			usba_r <= pwdata & USBA_WMASK;
	end

	// USB configuration B: low-power and latency messaging defaults
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			usbb_r <= RST_USBB;
		else if (lite_reset)
			usbb_r <= RST_USBB;
		else if (apply)
		begin
			usbb_r                  <= ZERO32;
			usbb_r[USBB_DEEP_INIT]  <= cfg0[CF_DEEP_INIT];
			usbb_r[USBB_DEEP_EN]    <= cfg0[CF_DEEP_EN];
			usbb_r[USBB_LIGHT_INIT] <= cfg0[CF_LIGHT_INIT];
			usbb_r[USBB_LIGHT_EN]   <= cfg0[CF_LIGHT_EN];
			usbb_r[USBB_LTM]        <= cfg0[CF_LTM];
		end
		else if (wr_hit(OFS_USB_B))
			usbb_r <= pwdata & USBB_WMASK;
	end

	// Wakeup frame filter 0: config word then four mask words
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fcfg_r <= ZERO32;
			for (int i = 0; i < 4; i++)
				fmask_r[i] <= ZERO32;
		end
		else if (apply && wuf_want)
		begin
			fcfg_r <= word_at(IDX_FILT);
			for (int i = 0; i < 4; i++)
				fmask_r[i] <= word_at(IDX_FILT_MASK + IDX_W'(4 * i));
		end
		else if (wr_hit(OFS_FILT_CFG))
			fcfg_r <= pwdata;
		else
		begin
			for (int i = 0; i < 4; i++)
				if (wr_hit(OFS_FILT_MASK + APB_AW'(4 * i)))
					fmask_r[i] <= pwdata;
		end
	end

	// ------------------------------------------------------------------
	// Wake sources and power event pin
	// ------------------------------------------------------------------
	// Source enables only count while the master enable is set
	always_comb
	begin
		wake_en    = 5'h00;
		wake_en[0] = attr_r[ATTR_EXACT];
		wake_en[1] = attr_r[ATTR_PACKET];
		wake_en[2] = attr_r[ATTR_LINK];
		wake_en[3] = attr_r[ATTR_BCAST];
		wake_en[4] = attr_r[ATTR_WUF];
		if (!attr_r[ATTR_MASTER])
			wake_en = 5'h00;
	end

	// Sticky pending; a new event wins over a same-cycle clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pend_r <= 5'h00;
		else if (lite_reset)
			pend_r <= 5'h00;
		else if (wr_hit(OFS_WAKE_STAT))
			pend_r <= (pend_r & ~pwdata[4:0]) | (wake_ev & wake_en);
		else
			pend_r <= pend_r | (wake_ev & wake_en);
	end

	// Pin asserted low only while enabled and something is pending
	assign power_event_pin_n = !(attr_r[ATTR_MASTER] && |pend_r);

	// ------------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------------
	// Decode for both read data and the unmapped-address error
	always_comb
	begin
		rd_nxt = ZERO32;
		rd_hit = 1'b1;
		if (paddr == OFS_LOADER)
		begin
			rd_nxt[LDS_DONE]  = (state_r == LD_DONE);
			rd_nxt[LDS_VALID] = valid_r;
			rd_nxt[LDS_BUSY]  = (state_r != LD_DONE);
		end
		else if (paddr == OFS_ATTR)
			rd_nxt = attr_r;
		else if (paddr == OFS_HWCFG)
			rd_nxt = hwc_r;
		else if (paddr == OFS_IND_MODE)
			rd_nxt = mode_r;
		else if (paddr == OFS_IND_BEHAV)
			rd_nxt = behav_r;
		else if (paddr == OFS_AFE)
			rd_nxt = afe_r;
		else if (paddr == OFS_USB_A)
			rd_nxt = usba_r;
		else if (paddr == OFS_USB_B)
			rd_nxt = usbb_r;
		else if (paddr == OFS_WAKE_STAT)
			rd_nxt = {27'h0, pend_r};
		else if (paddr == OFS_FILT_CFG)
			rd_nxt = fcfg_r;
		else if (paddr >= OFS_FILT_MASK && paddr <= OFS_FILT_LAST
			&& paddr[1:0] == 2'b00)
			rd_nxt = fmask_r[paddr[3:2] - 2'h2];
		else
			rd_hit = 1'b0;
	end

	// Read data captured in the setup cycle, shown in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata_r <= ZERO32;
		else if (psel && !penable && !pwrite)
			prdata_r <= rd_nxt;
	end

	assign prdata  = prdata_r;
	assign pready  = 1'b1; // Zero-wait slave
	assign pslverr = acc && !rd_hit;

	// Live register values for the rest of the device
	assign cfg_out.wake_attr = attr_r;
	assign cfg_out.hardware_configuration_reg    = hwc_r;
	assign cfg_out.ind_mode  = mode_r;
	assign cfg_out.ind_behav = behav_r;
	assign cfg_out.afe_ctrl  = afe_r;
	assign cfg_out.usb_cfg_a = usba_r;
	assign cfg_out.usb_cfg_b = usbb_r;
	assign cfg_out.filt_cfg  = fcfg_r;
	assign cfg_out.filt_mask = {fmask_r[3], fmask_r[2], fmask_r[1], fmask_r[0]};

endmodule : wlucl_loader

// File: wlucl_properties.sv
// Concurrent checks on the loader's ports
`timescale 1ns/1ps
module wlucl_properties
	import wlucl_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic [APB_AW-1:0] paddr,
	input wire logic              pslverr,
	input wire logic              lite_reset,
	input wlucl_mem_req_s         cfg_mem_out,
	input wire logic              cfg_mem_ack,
	input wlucl_wake_ev_s         wake_ev,
	input wire logic              power_event_pin_n,
	input wlucl_cfg_s             cfg_out
);
	// ------------------------------------------------------------
	// Helpers and properties
	// ------------------------------------------------------------
	logic       master;
	logic       arm;
	logic [4:0] hit;
	// Enabled sources in event bit order; soft reset drops pending
	assign master = cfg_out.wake_attr[ATTR_MASTER];
	assign arm = master && !lite_reset;
	assign hit = wake_ev & {cfg_out.wake_attr[ATTR_WUF],
		cfg_out.wake_attr[ATTR_BCAST], cfg_out.wake_attr[ATTR_LINK:ATTR_EXACT]};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_gate; !master |-> power_event_pin_n; endproperty
	a_gate: assert property (p_gate) else $error("pin low, master off");
	property p_link; hit[2] && arm |=> !power_event_pin_n; endproperty
	a_link: assert property (p_link) else $error("no link wake");
	property p_pkt; hit[1] && arm |-> ##1 !power_event_pin_n; endproperty
	a_pkt: assert property (p_pkt) else $error("no packet wake");
	property p_exact; hit[0] && arm |-> ##[1:1] !power_event_pin_n; endproperty
	a_exact: assert property (p_exact) else $error("no exact wake");
	property p_bcast; hit[3] && arm |=> !power_event_pin_n; endproperty
	a_bcast: assert property (p_bcast) else $error("no bcast wake");
	property p_wuf; hit[4] && arm |=> !power_event_pin_n; endproperty
	a_wuf: assert property (p_wuf) else $error("no frame wake");
	property p_prot; lite_reset && cfg_out.hardware_configuration_reg[HWC_PROTECT] |=>
		$stable(cfg_out.ind_mode) && $stable(cfg_out.ind_behav); endproperty
	a_prot: assert property (p_prot) else $error("indicator lost");
	property p_hold; cfg_mem_out.req && !cfg_mem_ack && !lite_reset |=>
		cfg_mem_out.req && $stable(cfg_mem_out.addr); endproperty
	a_hold: assert property (p_hold) else $error("request dropped");
	property p_drop; cfg_mem_out.req && cfg_mem_ack |=>
		!cfg_mem_out.req [*2]; endproperty
	a_drop: assert property (p_drop) else $error("request after ack");
	property p_err; psel && penable && paddr > OFS_FILT_LAST |-> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped not refused");
endmodule : wlucl_properties

// File: wlucl_mem_model.sv
// Behavioural configuration memory answering byte reads
`timescale 1ns/1ps
module wlucl_mem_model
	import wlucl_pkg::*;
(
	input wire logic       pclk,
	input wire logic       presetn,
	input wlucl_mem_req_s  req,
	input wire logic [3:0] lat,
	output logic           ack,
	output logic [7:0]     rdata
);
	// Image contents kept self-consistent by whoever programs it
	logic [7:0] mem [0:511] = '{default: 8'hFF};
	logic [3:0] cnt_r;
	// Answer after lat idle cycles; data toggles when not answering
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r <= 4'h0;
			ack <= 1'b0;
			rdata <= 8'h00;
		end
		else if (req.req && !ack && cnt_r == lat)
		begin
			ack <= 1'b1;
			rdata <= mem[req.addr];
			cnt_r <= 4'h0;
		end
		else
		begin
			ack <= 1'b0;
			rdata <= ~rdata;
			cnt_r <= (req.req && !ack) ? cnt_r + 4'h1 : 4'h0;
		end
	end
endmodule : wlucl_mem_model

// File: wlucl_loader_tb.sv
// Self-checking bench of the configuration loader
`timescale 1ns/1ps
module wlucl_loader_tb;
	import wlucl_pkg::*;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic              lite_reset = 1'b0;
	logic [APB_AW-1:0] paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [31:0]       prdata, rd;
	logic              pready, pslverr, err, cfg_mem_ack, power_event_pin_n;
	logic [7:0]        cfg_mem_rdata;
	logic [3:0]        lat = 4'h0;
	wlucl_mem_req_s    cfg_mem_out;
	wlucl_wake_ev_s    wake_ev = 5'h00;
	wlucl_cfg_s        cfg_out;
	int                errors = 0;
	int                tests_run = 0;
	int                i;
	int                ab [5] = '{0, 1, 2, 9, 8};
	logic [APB_AW-1:0] ra [10] = '{OFS_ATTR, OFS_HWCFG, OFS_IND_MODE,
		OFS_IND_BEHAV, OFS_AFE, OFS_USB_A, OFS_USB_B, OFS_FILT_CFG,
		OFS_FILT_MASK, OFS_LOADER};
	logic [31:0]       rv [10] = '{32'h387, 32'h0A, 32'h4321, 32'hC35A,
		32'h5, 32'h1, 32'h1A, 32'h44332211, 32'h04030201, 32'h3};
	// Clock at 200 MHz
	always #2.5 pclk = ~pclk;
	wlucl_loader dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .lite_reset, .cfg_mem_out,
		.cfg_mem_ack, .cfg_mem_rdata, .wake_ev, .power_event_pin_n, .cfg_out);
	wlucl_mem_model u_mem (.pclk, .presetn, .req(cfg_mem_out), .lat,
		.ack(cfg_mem_ack), .rdata(cfg_mem_rdata));
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic final_report;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Setup cycle, then hold until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			errors++;
			final_report();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge, so the next setup never re-drives psel in one step
		@(posedge pclk);
	endtask : apb
	// Poll the status word; bounded so a stuck load ends the run
	task automatic wait_done;
		int n;
		n = 0;
		do
		begin
			apb(1'b0, OFS_LOADER, 32'h0);
			n++;
		end
		while (rd[LDS_DONE] !== 1'b1 && n < 300);
		if (n >= 300)
		begin
			errors++;
			final_report();
		end
	endtask : wait_done
	task automatic reload;
		lite_reset <= 1'b1;
		@(posedge pclk);
		lite_reset <= 1'b0;
		wait_done();
	endtask : reload
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		u_mem.mem[MEM_SIG_ADDR] = SIG_VALUE;
		u_mem.mem[MEM_IND0_ADDR] = 8'hFA;
		u_mem.mem[MEM_IND1_ADDR] = 8'h21;
		u_mem.mem[MEM_IND2_ADDR] = 8'h43;
		u_mem.mem[MEM_IND3_ADDR] = 8'h5A;
		u_mem.mem[MEM_IND4_ADDR] = 8'hC3;
		u_mem.mem[MEM_CFG0_ADDR] = 8'h00;
		u_mem.mem[MEM_CFG0_ADDR + 1] = 8'h00;
		u_mem.mem[MEM_CFG0_ADDR + 2] = 8'h70;
		u_mem.mem[MEM_CFG0_ADDR + 3] = 8'hED;
		for (i = 0; i < 4; i++)
		begin
			u_mem.mem[MEM_FILT_ADDR + i] = 8'(8'h11 * (i + 1));
			u_mem.mem[MEM_FILT_ADDR + 4 + i] = 8'(i + 1);
		end
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wait_done();
		for (i = 0; i < 10; i++)
		begin
			apb(1'b0, ra[i], 32'h0);
			chk(rd, rv[i]);
		end
		chk(cfg_out.ind_behav, 32'hC35A);
		// Only the one enabled source may pull the pin
		for (i = 0; i < 5; i++)
		begin
			apb(1'b1, OFS_ATTR, 32'h80 | (32'h1 << ab[i]));
			wake_ev <= 5'h1F & ~(5'h01 << i);
			@(posedge pclk);
			wake_ev <= 5'h01 << i;
			@(negedge pclk);
			chk(32'(power_event_pin_n), 32'h1);
			@(posedge pclk);
			wake_ev <= 5'h00;
			@(negedge pclk);
			chk(32'(power_event_pin_n), 32'h0);
			@(posedge pclk);
			apb(1'b1, OFS_WAKE_STAT, 32'h1F);
			@(negedge pclk);
			chk(32'(power_event_pin_n), 32'h1);
			@(posedge pclk);
		end
		apb(1'b1, OFS_ATTR, 32'h307);
		wake_ev <= 5'h1F;
		@(posedge pclk);
		wake_ev <= 5'h00;
		apb(1'b1, OFS_ATTR, 32'h387);
		@(negedge pclk);
		chk(32'(power_event_pin_n), 32'h1);
		@(posedge pclk);
		apb(1'b0, 8'h40, 32'h0);
		chk(32'(err), 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, OFS_HWCFG, 32'h10);
		apb(1'b1, OFS_IND_MODE, 32'hBEEF);
		reload();
		apb(1'b0, OFS_IND_MODE, 32'h0);
		chk(rd, 32'hBEEF);
		apb(1'b0, OFS_HWCFG, 32'h0);
		chk(rd, 32'h1A);
		apb(1'b1, OFS_HWCFG, 32'h0);
		// Frame wake off: the filter keeps what software wrote
		u_mem.mem[MEM_WAKE1_ADDR] = 8'h02;
		apb(1'b1, OFS_FILT_CFG, 32'h0);
		reload();
		apb(1'b0, OFS_IND_MODE, 32'h0);
		chk(rd, 32'h4321);
		apb(1'b0, OFS_ATTR, 32'h0);
		chk(rd, 32'h287);
		apb(1'b0, OFS_FILT_CFG, 32'h0);
		chk(rd, 32'h0);
		// Bad signature with a slow memory: nothing may be loaded
		u_mem.mem[MEM_SIG_ADDR] = ~SIG_VALUE;
		lat <= 4'h3;
		reload();
		chk(rd, 32'h1);
		apb(1'b0, OFS_ATTR, 32'h0);
		chk(rd, RST_ATTR);
		final_report();
	end
endmodule : wlucl_loader_tb
bind wlucl_loader wlucl_properties u_props (.pclk, .presetn, .psel, .penable,
	.paddr, .pslverr, .lite_reset, .cfg_mem_out, .cfg_mem_ack, .wake_ev,
	.power_event_pin_n, .cfg_out);
